// >>> hdl/scr_pkg.sv
// shared constants for the strap configuration register bank
package scr_pkg;
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 16;
	localparam logic [7:0] OFF_CHIP_CFG      = 8'h08;
	localparam logic [7:0] OFF_MAC_LOW       = 8'h10;
	localparam logic [7:0] OFF_MAC_MID       = 8'h12;
	localparam logic [7:0] OFF_MAC_HIGH      = 8'h14;
	localparam logic [7:0] OFF_POWER_EVENT   = 8'hD4;
	localparam logic [7:0] OFF_SLEEP_WAKE    = 8'hD6;
	localparam logic [7:0] OFF_PHY_RESET     = 8'hD8;
	localparam logic [7:0] OFF_PHY_BCTRL     = 8'hE4;
	localparam logic [7:0] OFF_PHY_BSTAT     = 8'hE6;
	localparam logic [7:0] OFF_PHY_ID_LOW    = 8'hE8;
	localparam logic [7:0] OFF_PHY_ID_HIGH   = 8'hEA;
	localparam logic [7:0] OFF_AUTONEG_ADV   = 8'hEC;
	localparam logic [7:0] OFF_PARTNER_ABIL  = 8'hEE;
	localparam logic [7:0] OFF_CABLE_DIAG    = 8'hF4;
	localparam logic [7:0] OFF_PORT_CTRL     = 8'hF6;
	localparam logic [7:0] OFF_PORT_STAT     = 8'hF8;
	localparam logic [15:0] RST_POWER_EVENT  = 16'h0080;
	localparam logic [15:0] RST_SLEEP_WAKE   = 16'h080C;
	localparam logic [15:0] RST_PHY_RESET    = 16'h0000;
	localparam logic [15:0] RST_PHY_BCTRL    = 16'h3120;
	localparam logic [15:0] RST_PHY_BSTAT    = 16'h7808;
	localparam logic [15:0] RST_AUTONEG_ADV  = 16'h05E1;
	localparam logic [15:0] RST_PARTNER_ABIL = 16'h0001;
	localparam logic [15:0] RST_CABLE_DIAG   = 16'h0000;
	localparam logic [15:0] RST_PORT_CTRL    = 16'h00FF;
	localparam logic [15:0] RST_PORT_STAT    = 16'h8080;
	localparam logic [15:0] RST_MAC_WORD     = 16'h0000;
	// write-one-clear positions in the power event register (low nibble)
	localparam logic [15:0] POWER_EVENT_CLR  = 16'h000F;
	localparam int unsigned CFG_ENDIAN_BIT   = 10;
	localparam int unsigned CFG_EEPROM_BIT   = 9;
	localparam int unsigned CFG_BUS8_BIT     = 7;
	localparam int unsigned CFG_BUS16_BIT    = 6;
	localparam int unsigned CFG_SHARED_BIT   = 4;
	localparam int unsigned CFG_PKG48_BIT    = 1;
	localparam logic [1:0] EE_WORD_FIRST     = 2'h1;
	localparam logic [1:0] EE_WORD_LAST      = 2'h3;
	typedef enum logic [1:0] {
		SCR_LD_IDLE = 2'b00,
		SCR_LD_REQ  = 2'b01,
		SCR_LD_WAIT = 2'b10,
		SCR_LD_DONE = 2'b11
	} scr_load_state_t;
endpackage

// >>> hdl/scr_strap_if.sv
// strap capture results passed from the sampler to the register bank
interface scr_strap_if;
	logic little_endian;
	logic eeprom_fitted;
	logic bus_8bit;
	logic valid;
	modport sampler (output little_endian, output eeprom_fitted,
		output bus_8bit, output valid);
	modport bank (input little_endian, input eeprom_fitted,
		input bus_8bit, input valid);
endinterface

// >>> hdl/scr_strap_sampler.sv
// synchronises strap pins and latches them once after reset release
module scr_strap_sampler (
	input  wire logic ref_clk_in,
	input  wire logic rst_n_in,
	input  wire logic endian_strap_in,
	input  wire logic eeprom_strap_in,
	input  wire logic led_strap_in,
	scr_strap_if.sampler strap
);
	logic [2:0] meta_q;
	logic [2:0] sync_q;
	logic [1:0] settle_q;
	logic       little_endian_q;
	logic       eeprom_fitted_q;
	logic       bus_8bit_q;
	logic       valid_q;

	always_ff @(posedge ref_clk_in) begin
		meta_q <= {endian_strap_in, eeprom_strap_in, led_strap_in};
		sync_q <= meta_q;
	end

	// wait for synchroniser to fill with post-release values
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			settle_q <= 2'h0;
		end else if (settle_q != 2'h3) begin
			settle_q <= settle_q + 2'h1;
		end
	end

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			valid_q         <= 1'b0;
			little_endian_q <= 1'b0;
			eeprom_fitted_q <= 1'b0;
			bus_8bit_q      <= 1'b0;
		end else if (settle_q == 2'h3 && !valid_q) begin
			// later pin activity (endian, eeprom, led) is ignored
			valid_q         <= 1'b1;
			little_endian_q <= sync_q[2];
			eeprom_fitted_q <= sync_q[1];
			bus_8bit_q      <= ~sync_q[0];
		end
	end

	assign strap.little_endian = little_endian_q;
	assign strap.eeprom_fitted = eeprom_fitted_q;
	assign strap.bus_8bit      = bus_8bit_q;
	assign strap.valid         = valid_q;
endmodule

// >>> hdl/scr_reg_bank.sv
// upper register bank with strap configuration and mac address load
// How it works
// - writing one clears write-one-clear bits
// - configuration register read only, 15-11 zero
// - bit 10 latches endian strap
// - bit 9 latches eeprom presence strap
// - bit 7 shows 8-bit bus mode
// - bit 6 shows 16-bit bus mode
// - bit 4 shows shared address/data bus
// - bit 1 shows 48-pin package, set from PACKAGE_48
// - byte access: even low, odd high
// - power and sleep timing reset values
// - phy control, status, advert reset values
// - port, partner, reset, diag reset values
// - load mac address from eeprom words
module scr_reg_bank
	import scr_pkg::*;
#(
	// identification words: arbitrary values, no real part's code
	parameter logic [15:0] PHY_ID_LOW_VAL  = 16'hA5A5,
	parameter logic [15:0] PHY_ID_HIGH_VAL = 16'h5A5A,
	parameter bit          SHARED_BUS      = 1'b1,
	parameter bit          PACKAGE_48      = 1'b1
) (
	input  wire logic              ref_clk_in,
	input  wire logic              rst_n_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] wdata_in,
	input  wire logic [1:0]        byte_en_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	output logic      [DATA_W-1:0] rdata_out,
	input  wire logic              endian_strap_in,
	input  wire logic              eeprom_strap_in,
	input  wire logic              led_strap_in,
	output logic                   ee_req_out,
	output logic      [1:0]        ee_word_out,
	input  wire logic              ee_ack_in,
	input  wire logic [DATA_W-1:0] ee_data_in,
	output logic                   phy_reset_out,
	output logic      [DATA_W-1:0] power_event_out,
	output logic      [DATA_W-1:0] sleep_wake_out,
	output logic                   mac_loaded_out
);
	scr_strap_if strap ();

	scr_strap_sampler u_sampler (
		.ref_clk_in      (ref_clk_in),
		.rst_n_in        (rst_n_in),
		.endian_strap_in (endian_strap_in),
		.eeprom_strap_in (eeprom_strap_in),
		.led_strap_in    (led_strap_in),
		.strap           (strap)
	);

	logic [DATA_W-1:0] power_event_q;
	logic [DATA_W-1:0] sleep_wake_q;
	logic [DATA_W-1:0] phy_reset_q;
	logic [DATA_W-1:0] phy_bctrl_q;
	logic [DATA_W-1:0] phy_bstat_q;
	logic [DATA_W-1:0] autoneg_adv_q;
	logic [DATA_W-1:0] partner_abil_q;
	logic [DATA_W-1:0] cable_diag_q;
	logic [DATA_W-1:0] port_ctrl_q;
	logic [DATA_W-1:0] port_stat_q;
	logic [DATA_W-1:0] mac_q [3];
	logic [DATA_W-1:0] chip_cfg;
	logic [DATA_W-1:0] wmask;
	logic [DATA_W-1:0] rdata_d;
	logic [DATA_W-1:0] rdata_q;
	logic [ADDR_W-1:0] word_addr;
	logic [1:0]        ee_word_q;
	logic              ee_load;
	scr_load_state_t   ld_state_q;

	// byte lanes: even address low, odd address high
	function automatic logic [DATA_W-1:0] lane_mask(logic [1:0] be);
		lane_mask = {{8{be[1]}}, {8{be[0]}}};
	endfunction

	function automatic logic [DATA_W-1:0] merge(logic [DATA_W-1:0] old,
		logic [DATA_W-1:0] nw, logic [DATA_W-1:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction

	assign word_addr = {addr_in[ADDR_W-1:1], 1'b0};
	assign wmask     = lane_mask(byte_en_in);

	// read-only view of sampled straps and bonding
	always_comb begin
		chip_cfg                 = 16'h0000;
		chip_cfg[CFG_ENDIAN_BIT] = strap.little_endian;
		chip_cfg[CFG_EEPROM_BIT] = strap.eeprom_fitted;
		chip_cfg[CFG_BUS8_BIT]   = strap.bus_8bit;
		chip_cfg[CFG_BUS16_BIT]  = ~strap.bus_8bit;
		chip_cfg[CFG_SHARED_BIT] = SHARED_BUS;
		chip_cfg[CFG_PKG48_BIT]  = PACKAGE_48;
	end

	// plain read/write registers; host keeps reserved bits itself
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			sleep_wake_q   <= RST_SLEEP_WAKE;
			phy_reset_q    <= RST_PHY_RESET;
			phy_bctrl_q    <= RST_PHY_BCTRL;
			autoneg_adv_q  <= RST_AUTONEG_ADV;
			cable_diag_q   <= RST_CABLE_DIAG;
			port_ctrl_q    <= RST_PORT_CTRL;
		end else if (wr_in) begin
			case (word_addr)
				OFF_SLEEP_WAKE: sleep_wake_q <=
					merge(sleep_wake_q, wdata_in, wmask);
				OFF_PHY_RESET: phy_reset_q <=
					merge(phy_reset_q, wdata_in, wmask);
				OFF_PHY_BCTRL: phy_bctrl_q <=
					merge(phy_bctrl_q, wdata_in, wmask);
				OFF_AUTONEG_ADV: autoneg_adv_q <=
					merge(autoneg_adv_q, wdata_in, wmask);
				OFF_CABLE_DIAG: cable_diag_q <=
					merge(cable_diag_q, wdata_in, wmask);
				OFF_PORT_CTRL: port_ctrl_q <=
					merge(port_ctrl_q, wdata_in, wmask);
				default: ;
			endcase
		end
	end

	// status words without a live phy behind them keep reset values
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			phy_bstat_q    <= RST_PHY_BSTAT;
			partner_abil_q <= RST_PARTNER_ABIL;
			port_stat_q    <= RST_PORT_STAT;
		end
	end

	// event flags: host ones clear them, never set them
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			power_event_q <= RST_POWER_EVENT;
		end else if (wr_in && word_addr == OFF_POWER_EVENT) begin
			power_event_q <=
				(merge(power_event_q, wdata_in, wmask & ~POWER_EVENT_CLR))
				& ~(wdata_in & wmask & POWER_EVENT_CLR);
		end
	end

	// mac address load from eeprom words 1..3 once straps are known
	assign ee_load = (ld_state_q == SCR_LD_WAIT) && ee_ack_in;

	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			ld_state_q <= SCR_LD_IDLE;
			ee_word_q  <= EE_WORD_FIRST;
		end else begin
			case (ld_state_q)
				SCR_LD_IDLE: begin
					if (strap.valid) begin
						ld_state_q <= strap.eeprom_fitted ? SCR_LD_REQ
							: SCR_LD_DONE;
					end
				end
				SCR_LD_REQ: ld_state_q <= SCR_LD_WAIT;
				SCR_LD_WAIT: begin
					if (ee_ack_in) begin
						if (ee_word_q == EE_WORD_LAST) begin
							ld_state_q <= SCR_LD_DONE;
						end else begin
							ee_word_q  <= ee_word_q + 2'h1;
							ld_state_q <= SCR_LD_REQ;
						end
					end
				end
				SCR_LD_DONE: ld_state_q <= SCR_LD_DONE;
				default: ld_state_q <= SCR_LD_IDLE;
			endcase
		end
	end

	// software may overwrite the loaded address afterwards
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			mac_q[0] <= RST_MAC_WORD;
			mac_q[1] <= RST_MAC_WORD;
			mac_q[2] <= RST_MAC_WORD;
		end else if (ee_load) begin
			mac_q[ee_word_q - EE_WORD_FIRST] <= ee_data_in;
		end else if (wr_in) begin
			case (word_addr)
				OFF_MAC_LOW:  mac_q[0] <= merge(mac_q[0], wdata_in, wmask);
				OFF_MAC_MID:  mac_q[1] <= merge(mac_q[1], wdata_in, wmask);
				OFF_MAC_HIGH: mac_q[2] <= merge(mac_q[2], wdata_in, wmask);
				default: ;
			endcase
		end
	end

	always_comb begin
		case (word_addr)
			OFF_CHIP_CFG:     rdata_d = chip_cfg;
			OFF_MAC_LOW:      rdata_d = mac_q[0];
			OFF_MAC_MID:      rdata_d = mac_q[1];
			OFF_MAC_HIGH:     rdata_d = mac_q[2];
			OFF_POWER_EVENT:  rdata_d = power_event_q;
			OFF_SLEEP_WAKE:   rdata_d = sleep_wake_q;
			OFF_PHY_RESET:    rdata_d = phy_reset_q;
			OFF_PHY_BCTRL:    rdata_d = phy_bctrl_q;
			OFF_PHY_BSTAT:    rdata_d = phy_bstat_q;
			OFF_PHY_ID_LOW:   rdata_d = PHY_ID_LOW_VAL;
			OFF_PHY_ID_HIGH:  rdata_d = PHY_ID_HIGH_VAL;
			OFF_AUTONEG_ADV:  rdata_d = autoneg_adv_q;
			OFF_PARTNER_ABIL: rdata_d = partner_abil_q;
			OFF_CABLE_DIAG:   rdata_d = cable_diag_q;
			OFF_PORT_CTRL:    rdata_d = port_ctrl_q;
			OFF_PORT_STAT:    rdata_d = port_stat_q;
			default:          rdata_d = 16'h0000;
		endcase
	end

	// in 8-bit bus mode an odd byte address returns the high byte on the low lane
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			rdata_q <= 16'h0000;
		end else if (rd_in) begin
			if (strap.bus_8bit) begin
				rdata_q <= addr_in[0] ? {8'h00, rdata_d[15:8]}
					: {8'h00, rdata_d[7:0]};
			end else begin
				rdata_q <= rdata_d;
			end
		end
	end

	assign rdata_out       = rdata_q;
	assign ee_req_out      = (ld_state_q == SCR_LD_REQ);
	assign ee_word_out     = ee_word_q;
	assign phy_reset_out   = phy_reset_q[15];
	assign power_event_out = power_event_q;
	assign sleep_wake_out  = sleep_wake_q;
	assign mac_loaded_out  = (ld_state_q == SCR_LD_DONE);
endmodule

// >>> verification/scr_eeprom_model.sv
// behavioural serial eeprom that answers word fetches after a delay
module scr_eeprom_model #(
	parameter int DELAY = 3
) (
	input  wire logic        clk_in,
	input  wire logic        req_in,
	input  wire logic [1:0]  word_in,
	output logic             ack_out,
	output logic      [15:0] data_out
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] rom [4];
	logic [1:0]  w;
	initial begin
		rom = '{16'h0000, 16'h89AB, 16'h4567, 16'h0123};
		ack_out = 1'b0;
		data_out = 16'h0000;
		forever begin
			@(posedge clk_in);
			if (req_in === 1'b1) begin
				w = word_in;
				repeat (DELAY) @(posedge clk_in);
				#2 ack_out = 1'b1;
				data_out = rom[w];
				@(posedge clk_in);
				// data not held past the ack: show something wrong
				#2 ack_out = 1'b0;
				data_out = ~rom[w];
			end
		end
	end
endmodule

// >>> verification/scr_reg_bank_properties.sv
// port-level assertions for the register bank
module scr_reg_bank_props
	import scr_pkg::*;
(
	input wire logic              ref_clk_in,
	input wire logic              rst_n_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wdata_in,
	input wire logic [1:0]        byte_en_in,
	input wire logic              wr_in,
	input wire logic              rd_in,
	input wire logic [DATA_W-1:0] rdata_out,
	input wire logic              ee_req_out,
	input wire logic [1:0]        ee_word_out,
	input wire logic              phy_reset_out,
	input wire logic [DATA_W-1:0] power_event_out,
	input wire logic [DATA_W-1:0] sleep_wake_out,
	input wire logic              mac_loaded_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!rst_n_in);
	chk_flag_clears: assert property (
		wr_in && addr_in == OFF_POWER_EVENT && byte_en_in[0] |=>
		(power_event_out & $past(wdata_in) & POWER_EVENT_CLR) == 16'h0000)
		else $error("write-one-clear bit survived a write of one");
	chk_flag_never_set: assert property (
		wr_in && addr_in == OFF_POWER_EVENT |=>
		(power_event_out & ~$past(power_event_out) & POWER_EVENT_CLR) == 0)
		else $error("write-one-clear bit set by a host write");
	chk_sleep_word_write: assert property (
		wr_in && addr_in == OFF_SLEEP_WAKE && byte_en_in == 2'h3 |=>
		sleep_wake_out == $past(wdata_in))
		else $error("sleep timing word write not applied");
	chk_phy_reset_cause: assert property (
		$rose(phy_reset_out) |-> $past(wr_in) &&
		$past(addr_in[7:1]) == OFF_PHY_RESET[7:1])
		else $error("phy reset rose without a write to it");
	chk_power_reset_vals: assert property (
		$rose(rst_n_in) |-> power_event_out == RST_POWER_EVENT &&
		sleep_wake_out == RST_SLEEP_WAKE)
		else $error("power or sleep register reset value wrong");
	chk_ee_word_range: assert property (
		ee_req_out |-> ee_word_out inside {[EE_WORD_FIRST:EE_WORD_LAST]})
		else $error("eeprom word index out of range");
	chk_ee_req_pulse: assert property (
		ee_req_out |=> !ee_req_out)
		else $error("eeprom request longer than one cycle");
	chk_mac_load_holds: assert property (
		mac_loaded_out && !ee_req_out |=> mac_loaded_out && !ee_req_out)
		else $error("mac load restarted after completion");
	chk_cfg_reserved_zero: assert property (
		rd_in && addr_in == OFF_CHIP_CFG |=> rdata_out[15:11] == 5'h00 &&
		rdata_out[8] == 1'b0 && rdata_out[5] == 1'b0 &&
		rdata_out[3:2] == 2'h0 && rdata_out[0] == 1'b0)
		else $error("reserved configuration bits not zero");
endmodule

bind scr_reg_bank scr_reg_bank_props i_props (
	.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .addr_in(addr_in),
	.wdata_in(wdata_in), .byte_en_in(byte_en_in), .wr_in(wr_in),
	.rd_in(rd_in), .rdata_out(rdata_out), .ee_req_out(ee_req_out),
	.ee_word_out(ee_word_out), .phy_reset_out(phy_reset_out),
	.power_event_out(power_event_out), .sleep_wake_out(sleep_wake_out),
	.mac_loaded_out(mac_loaded_out));

// >>> verification/strap_config_register_map_bench.sv
// self-checking bench for the strap configuration register bank
module strap_config_register_map_bench
	import scr_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, rst_n, wr, rd, es, ds, ls, ack, req, prst, ml;
	logic [7:0]  addr;
	logic [15:0] wd, rdata, pe, sw, ed;
	logic [1:0]  be, word;
	int          n_errors, n_checks;
	logic [7:0]  ra [15] = '{8'hD4, 8'hD6, 8'hD8, 8'hE4, 8'hE6, 8'hEC,
		8'hEE, 8'hF4, 8'hF6, 8'hF8, 8'hDA, 8'h08, 8'h10, 8'h12, 8'h14};
	logic [15:0] re [15] = '{16'h0080, 16'h080C, 16'h0000, 16'h3120,
		16'h7808, 16'h05E1, 16'h0001, 16'h0000, 16'h00FF, 16'h8080,
		16'h0000, 16'h0652, 16'h89AB, 16'h4567, 16'h0123};
	scr_reg_bank i_dut (.ref_clk_in(clk), .rst_n_in(rst_n), .addr_in(addr),
		.wdata_in(wd), .byte_en_in(be), .wr_in(wr), .rd_in(rd),
		.rdata_out(rdata), .endian_strap_in(es), .eeprom_strap_in(ds),
		.led_strap_in(ls), .ee_req_out(req), .ee_word_out(word),
		.ee_ack_in(ack), .ee_data_in(ed), .phy_reset_out(prst),
		.power_event_out(pe), .sleep_wake_out(sw), .mac_loaded_out(ml));
	scr_eeprom_model i_ee (.clk_in(clk), .req_in(req), .word_in(word),
		.ack_out(ack), .data_out(ed));
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wrt(logic [7:0] a, logic [15:0] d, logic [1:0] b);
		addr = a;
		wd = d;
		be = b;
		wr = 1'b1;
		@(posedge clk);
		#2 wr = 1'b0;
		@(posedge clk);
		#2;
	endtask
	task automatic rdc(logic [7:0] a, logic [15:0] e);
		addr = a;
		rd = 1'b1;
		@(posedge clk);
		#2 rd = 1'b0;
		chk($sformatf("read %h", a), e, rdata);
		// one idle edge so a following read never retoggles rd in a step
		@(posedge clk);
		#2;
	endtask
	// straps are only legal to move while reset is held
	task automatic rst_run(logic e, logic d, logic l);
		{es, ds, ls} = {e, d, l};
		rst_n = 1'b0;
		repeat (12) @(posedge clk);
		#2 rst_n = 1'b1;
		for (int i = 0; i < 100 && ml !== 1'b1; i++) @(posedge clk);
		repeat (8) @(posedge clk);
		#2 chk("mac loaded", 16'h0001, {15'h0, ml});
	endtask
	task automatic tally_and_finish();
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end
	initial begin
		#(25ns * 4000);
		n_errors++;
		$display("Error watchdog expected done seen timeout");
		tally_and_finish();
	end
	initial begin
		{wr, rd, addr, wd, be} = '0;
		rst_run(1'b1, 1'b1, 1'b1);
		for (int i = 0; i < 15; i++) rdc(ra[i], re[i]);
		$display("test reset rows done");
		wrt(OFF_CHIP_CFG, 16'hFFFF, 2'h3);
		rdc(OFF_CHIP_CFG, 16'h0652);
		wrt(OFF_SLEEP_WAKE, 16'h1234, 2'h3);
		chk("sleep out", 16'h1234, sw);
		rdc(OFF_SLEEP_WAKE, 16'h1234);
		wrt(OFF_POWER_EVENT, 16'h008F, 2'h3);
		chk("power out", 16'h0080, pe);
		wrt(OFF_PHY_RESET, 16'h8000, 2'h3);
		chk("phy reset", 16'h0001, {15'h0, prst});
		wrt(OFF_MAC_LOW, 16'hBEEF, 2'h3);
		rdc(OFF_MAC_LOW, 16'hBEEF);
		// host keeps the low byte by read, merge, write back while setting bit 8
		rdc(OFF_PORT_CTRL, RST_PORT_CTRL);
		wrt(OFF_PORT_CTRL, rdata | 16'h0100, 2'h3);
		rdc(OFF_PORT_CTRL, 16'h01FF);
		{es, ds, ls} = 3'b000;
		repeat (10) @(posedge clk);
		#2 rdc(OFF_CHIP_CFG, 16'h0652);
		$display("test writes done");
		rst_run(1'b0, 1'b0, 1'b0);
		rdc(8'h08, 16'h0092);
		rdc(8'h09, 16'h0000);
		rdc(8'hD6, 16'h000C);
		rdc(8'hD7, 16'h0008);
		rdc(8'h10, RST_MAC_WORD);
		$display("test byte mode done");
		tally_and_finish();
	end
endmodule
